// ===== dv/standby_halt_stop_control_tb_top.sv
/*
  Testbench joining host and controller ends over the link.
  Assumes a 25 MHz clock and software access over Avalon-MM only.
*/
`timescale 1ns/100ps

module standby_halt_stop_control_tb_top
  import standby_pkg::*;
;
  logic        sys_clk_i;
  logic        rst_b_i;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        irq_i;
  logic        periph_restart_o;
  logic        x1_osc_run_o;
  logic        hs_osc_run_o;
  logic        seen_gate;
  logic        seen_restart;
  int          n_errors;
  int          n_checks;
  int          cycles;
  logic [31:0] rd;

  standby_link_if lnk_if ();
  standby_host standby_host_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_i(irq_i),
    .periph_restart_o(periph_restart_o), .lnk(lnk_if.host));
  // Shortened stabilization count keeps the run brief
  standby_ctrl #(.STAB_SHIFT(6)) standby_ctrl_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .x1_osc_run_o(x1_osc_run_o), .hs_osc_run_o(hs_osc_run_o), .lnk(lnk_if.dev));
  standby_props standby_props_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .halt_req(lnk_if.halt_req), .stop_req(lnk_if.stop_req), .int_req(lnk_if.int_req),
    .int_ack_en(lnk_if.int_ack_en), .ext_clk_sel(lnk_if.ext_clk_sel),
    .lo_osc_stop(lnk_if.lo_osc_stop), .main_clock_status_bit(lnk_if.main_clock_status_bit),
    .cpu_clk_en(lnk_if.cpu_clk_en), .periph_clk_en(lnk_if.periph_clk_en),
    .lo_osc_run(lnk_if.lo_osc_run), .wake_vector(lnk_if.wake_vector),
    .wake_resume(lnk_if.wake_resume), .state(lnk_if.state));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (lnk_if.state === ST_GATE) seen_gate <= 1'b1;
    if (periph_restart_o === 1'b1) seen_restart <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic av_access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wait_state(input standby_state_t s);
    for (int i = 0; i < 3000 && lnk_if.state !== s; i++) @(posedge sys_clk_i);
    check(lnk_if.state === s, "state not reached");
  endtask

  task automatic t_early_refusals;
    av_access(1'b1, 4'h0, 32'h0000_0002);
    av_access(1'b1, 4'h4, 32'h0000_0052);
    av_access(1'b0, 4'hC, 32'h0);
    check(rd === 32'h0000_000C, "stop or select not refused");
    check(lnk_if.state === ST_RUN, "stop taken while unstable");
    av_access(1'b0, 4'h4, 32'h0);
    check(rd === 32'h0000_0050, "config readback");
    av_access(1'b0, 4'h2, 32'h0);
    check(rd === 32'h0, "unmapped read");
    for (int i = 0; i < 100 && lnk_if.hs_osc_stable_flag !== 1'b1; i++) @(posedge sys_clk_i);
    av_access(1'b0, 4'h8, 32'h0);
    check(rd[2:0] === 3'h3 && rd[10:8] === 3'h0, "status after settle");
    av_access(1'b1, 4'hC, 32'h0000_000F);
    // Internal oscillator switched off: stop must be refused
    av_access(1'b1, 4'h4, 32'h0000_0051);
    av_access(1'b1, 4'h0, 32'h0000_0002);
    av_access(1'b0, 4'hC, 32'h0);
    check(rd === 32'h0000_0004 && hs_osc_run_o === 1'b0, "stop with osc off");
    check(lnk_if.state === ST_RUN, "stop entered with osc off");
    av_access(1'b1, 4'h4, 32'h0000_0050);
    av_access(1'b1, 4'hC, 32'h0000_000F);
  endtask

  task automatic t_halt(input logic [31:0] cfg);
    av_access(1'b1, 4'h4, cfg);
    av_access(1'b1, 4'h0, 32'h0000_0001);
    wait_state(ST_HALT);
    check(lnk_if.cpu_clk_en === 1'b0 && lnk_if.periph_clk_en === 1'b1, "halt gating");
    irq_i <= 1'b1;
    wait_state(ST_WAIT);
    wait_state(ST_RUN);
    irq_i <= 1'b0;
    av_access(1'b0, 4'hC, 32'h0);
    check(rd[1:0] === (cfg[7] ? 2'h1 : 2'h2), "halt wake kind");
    av_access(1'b1, 4'hC, 32'h0000_000F);
  endtask

  task automatic t_stop(input logic [31:0] cfg);
    // Crystal may be selected only once its stabilization time is reached
    for (int i = 0; i < 2000 && cfg[1] && lnk_if.stab_counter_status[0] !== 1'b1; i++)
      @(posedge sys_clk_i);
    av_access(1'b1, 4'h4, cfg);
    av_access(1'b0, 4'h8, 32'h0);
    check(rd[0] === !cfg[3] && rd[2] === cfg[1], "osc control");
    seen_gate = 1'b0;
    seen_restart = 1'b0;
    av_access(1'b1, 4'h0, 32'h0000_0002);
    wait_state(ST_STOP);
    repeat (4) @(posedge sys_clk_i);
    check(lnk_if.periph_clk_en === 1'b0 && x1_osc_run_o === 1'b0
          && hs_osc_run_o === 1'b0, "oscillators in stop");
    check(lnk_if.lo_osc_run === !cfg[3], "low-speed osc kept");
    irq_i <= 1'b1;
    wait_state(ST_RUN);
    irq_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    // Gate only when amp is set and the CPU runs from internal or external clock
    check(seen_gate === (cfg[2] && !(cfg[1] && !cfg[8])), "clock gate use");
    check(seen_restart === 1'b1, "peripheral restart missing");
    av_access(1'b0, 4'hC, 32'h0);
    check(rd[1:0] === (cfg[7] ? 2'h1 : 2'h2), "stop wake kind");
    av_access(1'b1, 4'hC, 32'h0000_000F);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst_b_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    irq_i = 1'b0;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    seen_gate = 1'b0;
    seen_restart = 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_early_refusals();
    t_halt(32'h0000_04D0);
    t_halt(32'h0000_0550);
    t_halt(32'h0000_06D0);
    t_stop(32'h0000_04D4);
    t_stop(32'h0000_055C);
    t_stop(32'h0000_04D6);
    t_stop(32'h0000_05D6);
    print_verdict();
  end
endmodule // standby_halt_stop_control_tb_top

// ===== dv/standby_props.sv
/*
  Checker for the standby link between host and controller.
  Assumes one clock and the link signals as plain inputs.
*/
`timescale 1ns/100ps

module standby_props
  import standby_pkg::*;
(
  // Clock and reset
  input wire logic           sys_clk_i,
  input wire logic           rst_b_i,
  // Link signals
  input wire logic           halt_req,
  input wire logic           stop_req,
  input wire logic           int_req,
  input wire logic           int_ack_en,
  input wire logic           ext_clk_sel,
  input wire logic           lo_osc_stop,
  input wire logic           main_clock_status_bit,
  input wire logic           cpu_clk_en,
  input wire logic           periph_clk_en,
  input wire logic           lo_osc_run,
  input wire logic           wake_vector,
  input wire logic           wake_resume,
  input wire standby_state_t state
);
  logic [8:0] wait_cnt;
  logic [8:0] gate_cnt;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Cycle counters, too long for a repetition
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) wait_cnt <= 9'h000;
    else wait_cnt <= (state == ST_WAIT) ? wait_cnt + 9'h001 : 9'h000;
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) gate_cnt <= 9'h000;
    else gate_cnt <= (state == ST_GATE) ? gate_cnt + 9'h001 : 9'h000;
  end

  halt_entry_a: assert property (state == ST_RUN && halt_req && !stop_req |=>
    state == ST_HALT && !cpu_clk_en) else $error("halt not entered");
  stop_entry_a: assert property (state == ST_RUN && stop_req |=> state == ST_STOP)
    else $error("stop not entered");
  halt_gating_a: assert property (state == ST_HALT |-> !cpu_clk_en && periph_clk_en)
    else $error("halt gates wrong clocks");
  stop_release_a: assert property (state == ST_STOP && int_req |=> state == ST_STAB)
    else $error("stop not released");
  halt_release_a: assert property (state == ST_HALT && int_req |=> state == ST_WAIT)
    else $error("halt not released");
  lo_osc_keep_a: assert property (state == ST_STOP |-> lo_osc_run == !$past(lo_osc_stop))
    else $error("low-speed osc changed by stop");
  stab_skip_a: assert property (state == ST_STAB && !main_clock_status_bit |=>
    state != ST_STAB) else $error("stabilization wait on internal clock");
  wait_len_a: assert property (state == ST_RUN && wait_cnt != 9'h000 |->
    wait_cnt == (int_ack_en ? 9'd17 : 9'd11)) else $error("release wait length");
  wake_kind_a: assert property ($fell(state == ST_WAIT) |->
    (int_ack_en ? wake_vector && !wake_resume : wake_resume && !wake_vector))
    else $error("wrong wake kind");
  // External count applies only while the CPU really runs from the external input
  gate_len_a: assert property (state == ST_WAIT && gate_cnt != 9'h000 |->
    gate_cnt == ((ext_clk_sel && main_clock_status_bit) ? 9'd160 : 9'd102))
    else $error("clock gate length");
endmodule // standby_props

// ===== logic/standby_ctrl.sv
/*
  Device end: halt and stop sequencing, oscillator enables, stabilization
  counter, clock-supply gate and release wait for an 8-bit CPU.
  Assumes the host end keeps its software sequences and one 25 MHz clock.
*/
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "standby_regs.svh"

module standby_ctrl
  import standby_pkg::*;
#(
  parameter int unsigned STAB_SHIFT = 0
)(
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_b_i,
  // Clock outputs to the rest of the chip
  output logic               x1_osc_run_o,
  output logic               hs_osc_run_o,
  // Link
  standby_link_if.dev        lnk
);

  localparam int GATE_HS_CYC = int'($ceil(`GATE_MIN_US * `CLK_MHZ));

  standby_state_t           state;
  standby_state_t           next_state;
  cpu_clk_t                 cpu_src;
  logic [7:0]               wait_cnt;
  logic [`STAB_CNT_W-1:0]   stab_cnt;
  logic [`STAB_CNT_W-1:0]   stab_limit;
  logic [`STAB_CNT_W-1:0]   stab_sel_cnt;
  logic [3:0]               settle_cnt;
  logic                     stab_done;
  logic                     gate_needed;

  // Source of the CPU clock as steered by software
  always_comb begin
    if (lnk.sub_clk_sel) begin
      cpu_src = CLK_SUBSYSTEM;
    end else if (!lnk.main_clock_status_bit) begin
      cpu_src = CLK_INT_HS;
    end else if (lnk.ext_clk_sel) begin
      cpu_src = CLK_EXTERNAL;
    end else begin
      cpu_src = CLK_CRYSTAL;
    end
  end

  // Stabilization threshold; prohibited codes fall back to the longest
  function automatic logic [`STAB_CNT_W-1:0] stab_count(input logic [2:0] sel);
    logic [`STAB_CNT_W-1:0] full;
    full = {1'b1, {(`STAB_CNT_W-1){1'b0}}};
    unique case (sel)
      `STAB_SEL_2P11: stab_count = full >> (5 + STAB_SHIFT);
      `STAB_SEL_2P13: stab_count = full >> (3 + STAB_SHIFT);
      `STAB_SEL_2P14: stab_count = full >> (2 + STAB_SHIFT);
      `STAB_SEL_2P15: stab_count = full >> (1 + STAB_SHIFT);
      default:        stab_count = full >> STAB_SHIFT;
    endcase
  endfunction

  assign stab_limit   = stab_count(`STAB_SEL_2P16);
  assign stab_sel_cnt = stab_count(lnk.stab_time_select);
  assign stab_done    = stab_cnt >= stab_sel_cnt;

  // Gate applies only to the internal and external high-speed sources
  assign gate_needed = lnk.high_speed_amp_setting &&
                       (cpu_src == CLK_INT_HS || cpu_src == CLK_EXTERNAL);

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (lnk.stop_req) begin
          next_state = ST_STOP;
        end else if (lnk.halt_req) begin
          // Any CPU clock source is fine for halt
          next_state = ST_HALT;
        end
      end
      ST_HALT: begin
        if (lnk.int_req) begin
          next_state = ST_WAIT;
        end
      end
      ST_STOP: begin
        if (lnk.int_req) begin
          next_state = ST_STAB;
        end
      end
      ST_STAB: begin
        // Only a crystal needs the full wait; other sources run at once
        if (cpu_src != CLK_CRYSTAL || stab_done) begin
          next_state = gate_needed ? ST_GATE : ST_WAIT;
        end
      end
      ST_GATE: begin
        if (wait_cnt == 8'h01) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_cnt == 8'h01) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Shared down-counter for the clock gate and the release wait
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_cnt <= 8'h00;
    end else if (next_state == ST_GATE && state != ST_GATE) begin
      wait_cnt <= (cpu_src == CLK_EXTERNAL) ? `GATE_EXT_CLOCKS : 8'(GATE_HS_CYC);
    end else if (next_state == ST_WAIT && state != ST_WAIT) begin
      wait_cnt <= lnk.int_ack_en ? `WAIT_VECTOR_CLKS : `WAIT_RESUME_CLKS;
    end else if (wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end

  // Release outcome, one-cycle pulses
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk.wake_vector <= 1'b0;
      lnk.wake_resume <= 1'b0;
    end else begin
      lnk.wake_vector <= state == ST_WAIT && next_state == ST_RUN && lnk.int_ack_en;
      lnk.wake_resume <= state == ST_WAIT && next_state == ST_RUN && !lnk.int_ack_en;
    end
  end

  // Stabilization counter restarts whenever the crystal is stopped
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stab_cnt <= '0;
    end else if (state == ST_STOP) begin
      stab_cnt <= '0;
    end else if (stab_cnt < stab_limit) begin
      stab_cnt <= stab_cnt + 1'b1;
    end
  end

  // Status shows only thresholds up to the selected one
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk.stab_counter_status <= '0;
    end else begin
      lnk.stab_counter_status <= {
        stab_cnt >= stab_count(`STAB_SEL_2P11) && stab_sel_cnt >= stab_count(`STAB_SEL_2P11),
        stab_cnt >= stab_count(`STAB_SEL_2P13) && stab_sel_cnt >= stab_count(`STAB_SEL_2P13),
        stab_cnt >= stab_count(`STAB_SEL_2P14) && stab_sel_cnt >= stab_count(`STAB_SEL_2P14),
        stab_cnt >= stab_count(`STAB_SEL_2P15) && stab_sel_cnt >= stab_count(`STAB_SEL_2P15),
        stab_cnt >= stab_count(`STAB_SEL_2P16) && stab_sel_cnt >= stab_count(`STAB_SEL_2P16)
      };
    end
  end

  // Internal oscillator settle flag
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_cnt <= 4'h0;
    end else if (lnk.hs_osc_stop_bit || state == ST_STOP) begin
      settle_cnt <= 4'h0;
    end else if (settle_cnt != `HS_SETTLE_CLKS) begin
      settle_cnt <= settle_cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk.hs_osc_stable_flag    <= 1'b0;
      lnk.main_clock_status_bit <= 1'b0;
    end else begin
      lnk.hs_osc_stable_flag    <= settle_cnt == `HS_SETTLE_CLKS;
      // Status follows the select one clock later
      lnk.main_clock_status_bit <= lnk.main_clock_select_bit;
    end
  end

  // Oscillator enables; low-speed one ignores stop entirely
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk.lo_osc_run <= 1'b1;
      x1_osc_run_o   <= 1'b1;
      hs_osc_run_o   <= 1'b1;
    end else begin
      lnk.lo_osc_run <= !lnk.lo_osc_stop;
      x1_osc_run_o   <= next_state != ST_STOP;
      hs_osc_run_o   <= next_state != ST_STOP && !lnk.hs_osc_stop_bit;
    end
  end

  // Halt gates the CPU only; peripherals keep running to raise wakes
  assign lnk.cpu_clk_en    = state == ST_RUN;
  assign lnk.periph_clk_en = state != ST_STOP;
  assign lnk.state         = state;

endmodule // standby_ctrl

// ===== logic/standby_host.sv
/*
  Host end: CPU/interrupt side with an Avalon-MM register slave for software.
  Assumes the controller end on the link and one synchronous clock.
*/
`timescale 1ns/100ps
`include "standby_regs.svh"

module standby_host
  import standby_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          rst_b_i,
  // Avalon-MM slave
  input  wire logic [3:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  // Interrupt source and peripherals
  input  wire logic          irq_i,
  output logic               periph_restart_o,
  // Link
  standby_link_if.host       lnk
);

  logic        ack;
  logic        access;
  logic        wr_take;
  logic [10:0] cfg;
  logic [3:0]  flags;
  logic        in_stop;
  logic        stop_ok;
  logic        sel_ok;

  // One wait cycle per access so read data come from a flip-flop
  assign access            = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = access & ~ack;
  assign wr_take           = avs_write_i & ack;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack <= 1'b0;
    end else begin
      ack <= access & ~ack;
    end
  end

  // Stop only once the internal oscillator is stable
  assign stop_ok = lnk.hs_osc_stable_flag;
  // Back to crystal only after the longest (2^16) stabilization time, and only while the longest is selected
  assign sel_ok  = ~avs_writedata_i[`CFG_MAIN_SEL] | lnk.stab_counter_status[0];

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg <= 11'h000;
      cfg[`CFG_SEL_MSB:`CFG_SEL_LSB] <= `STAB_SEL_RESET;
    end else if (wr_take && avs_address_i == `REG_CFG) begin
      cfg <= avs_writedata_i[10:0];
      if (!sel_ok) begin
        cfg[`CFG_MAIN_SEL] <= cfg[`CFG_MAIN_SEL];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk.halt_req <= 1'b0;
      lnk.stop_req <= 1'b0;
    end else begin
      lnk.halt_req <= wr_take && avs_address_i == `REG_CTRL && avs_writedata_i[`CTRL_HALT];
      lnk.stop_req <= wr_take && avs_address_i == `REG_CTRL && avs_writedata_i[`CTRL_STOP]
                      && stop_ok;
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags <= 4'h0;
    end else begin
      if (wr_take && avs_address_i == `REG_FLAG) begin
        flags <= flags & ~avs_writedata_i[3:0];
      end
      if (lnk.wake_vector) begin
        flags[`FLAG_VECTOR] <= 1'b1;
      end
      if (lnk.wake_resume) begin
        flags[`FLAG_RESUME] <= 1'b1;
      end
      if (wr_take && avs_address_i == `REG_CTRL && avs_writedata_i[`CTRL_STOP] && !stop_ok) begin
        flags[`FLAG_STOP_REFUSED] <= 1'b1;
      end
      if (wr_take && avs_address_i == `REG_CFG && !sel_ok) begin
        flags[`FLAG_SEL_REFUSED] <= 1'b1;
      end
    end
  end

  // Peripherals stopped with their clocks are restarted after a stop wake
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      in_stop          <= 1'b0;
      periph_restart_o <= 1'b0;
    end else begin
      periph_restart_o <= in_stop & (lnk.wake_vector | lnk.wake_resume);
      if (lnk.state == ST_STOP) begin
        in_stop <= 1'b1;
      end else if (lnk.wake_vector | lnk.wake_resume) begin
        in_stop <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack) begin
      unique case (avs_address_i)
        `REG_CFG:  avs_readdata_o <= {21'h000000, cfg};
        `REG_STAT: avs_readdata_o <= {20'h00000, 1'b0, lnk.state, lnk.stab_counter_status,
                                      lnk.main_clock_status_bit, lnk.hs_osc_stable_flag,
                                      lnk.lo_osc_run};
        `REG_FLAG: avs_readdata_o <= {28'h0000000, flags};
        default:   avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  assign lnk.int_req                = irq_i & cfg[`CFG_IRQ_EN];
  assign lnk.int_ack_en             = cfg[`CFG_ACK_EN];
  assign lnk.hs_osc_stop_bit        = cfg[`CFG_HS_STOP];
  assign lnk.main_clock_select_bit  = cfg[`CFG_MAIN_SEL];
  assign lnk.ext_clk_sel            = cfg[`CFG_EXT_CLK];
  assign lnk.sub_clk_sel            = cfg[`CFG_SUB_CLK];
  assign lnk.high_speed_amp_setting = cfg[`CFG_AMP_HIGH];
  assign lnk.stab_time_select       = cfg[`CFG_SEL_MSB:`CFG_SEL_LSB];
  // Software stops the low-speed oscillator here before it issues stop
  assign lnk.lo_osc_stop            = cfg[`CFG_LO_STOP];

endmodule // standby_host

// ===== logic/standby_link_if.sv
/*
  Link between the CPU/interrupt side and the standby controller.
  Assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/100ps
`include "standby_regs.svh"

interface standby_link_if;
  import standby_pkg::*;

  logic                      halt_req;
  logic                      stop_req;
  logic                      int_req;
  logic                      int_ack_en;
  logic                      hs_osc_stop_bit;
  logic                      main_clock_select_bit;
  logic                      ext_clk_sel;
  logic                      sub_clk_sel;
  logic                      high_speed_amp_setting;
  logic                      lo_osc_stop;
  logic [2:0]                stab_time_select;
  logic                      cpu_clk_en;
  logic                      periph_clk_en;
  logic                      lo_osc_run;
  logic                      hs_osc_stable_flag;
  logic                      main_clock_status_bit;
  logic [`STAB_STAT_W-1:0]   stab_counter_status;
  logic                      wake_vector;
  logic                      wake_resume;
  standby_state_t            state;

  modport dev (
    input  halt_req, stop_req, int_req, int_ack_en, hs_osc_stop_bit,
           main_clock_select_bit, ext_clk_sel, sub_clk_sel,
           high_speed_amp_setting, lo_osc_stop, stab_time_select,
    output cpu_clk_en, periph_clk_en, lo_osc_run, hs_osc_stable_flag,
           main_clock_status_bit, stab_counter_status, wake_vector, wake_resume, state
  );

  modport host (
    output halt_req, stop_req, int_req, int_ack_en, hs_osc_stop_bit,
           main_clock_select_bit, ext_clk_sel, sub_clk_sel,
           high_speed_amp_setting, lo_osc_stop, stab_time_select,
    input  cpu_clk_en, periph_clk_en, lo_osc_run, hs_osc_stable_flag,
           main_clock_status_bit, stab_counter_status, wake_vector, wake_resume, state
  );

endinterface // standby_link_if

// ===== logic/standby_pkg.sv
/*
  Types shared by both ends of the standby link.
  Assumes nothing beyond the constants header.
*/
package standby_pkg;

  typedef enum logic [1:0] {
    CLK_INT_HS,
    CLK_CRYSTAL,
    CLK_EXTERNAL,
    CLK_SUBSYSTEM
  } cpu_clk_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_STAB,
    ST_GATE,
    ST_WAIT
  } standby_state_t;

endpackage

// ===== logic/standby_regs.svh
/*
  Constants for the standby controller and its host-side register block.
  Assumes a single 25 MHz system clock that also stands in for the crystal clock.
*/
`ifndef STANDBY_REGS_SVH
`define STANDBY_REGS_SVH

// Clock and timing
`define CLK_MHZ           25
`define GATE_MIN_US       4.06
`define GATE_EXT_CLOCKS   8'd160
`define WAIT_VECTOR_CLKS  8'd17
`define WAIT_RESUME_CLKS  8'd11
`define HS_SETTLE_CLKS    4'hF

// Stabilization time select codes and counter
`define STAB_SEL_RESET    3'h5
`define STAB_SEL_2P11     3'h1
`define STAB_SEL_2P13     3'h2
`define STAB_SEL_2P14     3'h3
`define STAB_SEL_2P15     3'h4
`define STAB_SEL_2P16     3'h5
`define STAB_CNT_W        17
`define STAB_STAT_W       5

// Host register byte offsets
`define REG_CTRL          4'h0
`define REG_CFG           4'h4
`define REG_STAT          4'h8
`define REG_FLAG          4'hC

// Control register bits
`define CTRL_HALT         0
`define CTRL_STOP         1

// Configuration register bits
`define CFG_HS_STOP       0
`define CFG_MAIN_SEL      1
`define CFG_AMP_HIGH      2
`define CFG_LO_STOP       3
`define CFG_SEL_LSB       4
`define CFG_SEL_MSB       6
`define CFG_ACK_EN        7
`define CFG_EXT_CLK       8
`define CFG_SUB_CLK       9
`define CFG_IRQ_EN        10

// Flag register bits
`define FLAG_VECTOR       0
`define FLAG_RESUME       1
`define FLAG_STOP_REFUSED 2
`define FLAG_SEL_REFUSED  3

`endif
